// >>> hw/phy_config_strap_decode.sv
// Purpose: Decode PHY strap pins and drive configuration and link status outputs.
// Assumes: All inputs synchronous to ref_clk; strap levels are sampled every cycle.
// Notes: Every output is registered, so outputs follow inputs by one clock, and control register writes by two.
// Notes: Released pins show low on the device side; the strap resistor sets the level.
`timescale 1ns/1ps

module phy_config_strap_decode
  import phy_strap_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire reg_req_type reg_req,
  output logic [31:0] reg_rdata,
  input wire logic config_source_select,
  input wire logic speed_select_pin_in,
  output logic speed_select_pin_out,
  output logic speed_select_pin_oe,
  input wire logic autoneg_select_pin_in,
  output logic autoneg_select_pin_out,
  output logic autoneg_select_pin_oe,
  input wire logic duplex_select_pin_in,
  output logic duplex_select_pin_out,
  output logic duplex_select_pin_oe,
  input wire logic host_if_select,
  input wire logic serial_or_pulse_select,
  input wire logic node_repeater_select,
  input wire logic descrambler_locked,
  input wire logic link_up,
  input wire logic rx_active,
  input wire logic tx_active,
  output logic descrambler_lock_out,
  output logic link_status_out,
  output logic signal_detect_out,
  output logic carrier_sense,
  output logic sqe_test_enable,
  output if_mode_type host_if_mode,
  output logic sw_mode_out,
  output logic speed_100,
  output logic full_duplex,
  output logic autoneg_enable,
  output logic repeater_mode
);

  ////////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  // Interface choice from speed, host select and serial or pulse select
  function automatic if_mode_type decode_if(input logic spd, input logic stream,
                                            input logic sp);
    if_mode_type m;
    m = IF_MII;
    if (!stream) begin
      m = IF_MII;
    end else if (spd) begin
      m = IF_SYMBOL;
    end else if (sp) begin
      m = IF_PULSE;
    end else begin
      m = IF_SERIAL;
    end
    return m;
  endfunction

  // Signal detect applies to symbol and serial interfaces
  function automatic logic uses_sd(input if_mode_type m);
    return (m == IF_SYMBOL) || (m == IF_SERIAL);
  endfunction

  // Two-way pin drive: enabled and showing the setting in software mode,
  // released and low in hardware mode so only the strap resistor sets the level
  function automatic pin_drive_type drive_pin(input logic sw, input logic val);
    pin_drive_type d;
    d.oe = sw;
    d.out = sw & val;
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // State

  strap_state_type state;
  strap_state_type next_state;
  logic [31:0] status_word;

  // Status word seen by a read
  // Built from registered state only, so a read never mixes two cycles
  always_comb begin
    status_word = 32'h0;
    status_word[STAT_SW_BIT] = state.sw_mode;
    status_word[STAT_SPEED_BIT] = state.eff.speed_100;
    status_word[STAT_DUPLEX_BIT] = state.eff.full_duplex;
    status_word[STAT_AUTONEG_BIT] = state.eff.autoneg;
    status_word[STAT_REPEATER_BIT] = state.repeater;
    status_word[STAT_IF_LSB +: 4] = state.if_mode;
    status_word[STAT_LOCK_BIT] = state.lock;
    status_word[STAT_LINK_BIT] = state.link;
  end

  // Next state of the whole block
  always_comb begin
    next_state = state;
    // Control register write
    if (reg_req.wr && (reg_req.addr == CTRL_ADDR)) begin
      next_state.ctrl.speed_100 = reg_req.wdata[CTRL_SPEED_BIT];
      next_state.ctrl.full_duplex = reg_req.wdata[CTRL_DUPLEX_BIT];
      next_state.ctrl.autoneg = reg_req.wdata[CTRL_AUTONEG_BIT];
    end
    // Read data for one cycle only
    next_state.rdata = 32'h0;
    if (reg_req.rd) begin
      if (reg_req.addr == CTRL_ADDR) begin
        next_state.rdata[CTRL_SPEED_BIT] = state.ctrl.speed_100;
        next_state.rdata[CTRL_DUPLEX_BIT] = state.ctrl.full_duplex;
        next_state.rdata[CTRL_AUTONEG_BIT] = state.ctrl.autoneg;
      end else if (reg_req.addr == STAT_ADDR) begin
        next_state.rdata = status_word;
      end else begin
        next_state.rdata = 32'h0;
      end
    end
    // Configuration source
    next_state.sw_mode = config_source_select;
    if (config_source_select) begin
      next_state.eff = state.ctrl;
    end else begin
      next_state.eff.speed_100 = speed_select_pin_in;
      next_state.eff.autoneg = autoneg_select_pin_in;
      next_state.eff.full_duplex = duplex_select_pin_in;
    end
    // Pin drive in software mode, same lag as the effective settings
    next_state.speed_pin = drive_pin(config_source_select, state.ctrl.speed_100);
    next_state.autoneg_pin = drive_pin(config_source_select, state.ctrl.autoneg);
    next_state.duplex_pin = drive_pin(config_source_select, state.ctrl.full_duplex);
    // Host interface
    // Decode uses the speed being loaded this edge, so mode and speed never disagree
    next_state.if_mode = decode_if(next_state.eff.speed_100, host_if_select,
                                   serial_or_pulse_select);
    // Node or repeater
    next_state.repeater = node_repeater_select;
    next_state.sqe_en = !node_repeater_select;
    // Carrier sense
    // Effective duplex, so software mode steers carrier sense as well
    if (!node_repeater_select && !next_state.eff.full_duplex) begin
      next_state.crs = rx_active | tx_active;
    end else begin
      next_state.crs = rx_active;
    end
    // Link status and lock
    next_state.lock = descrambler_locked;
    next_state.link = link_up;
    next_state.sd = link_up & uses_sd(next_state.if_mode);
  end

  // State register
  // Reset clears all but the control register, which takes its reset settings, and the interface mode, which parks on IF_MII
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state <= '0;
      state.ctrl <= CTRL_RESET;
      state.if_mode <= IF_MII;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Straight from the state register
  // No gate sits between a flop and a pin, so outputs never glitch
  assign reg_rdata = state.rdata;
  assign speed_select_pin_out = state.speed_pin.out;
  assign speed_select_pin_oe = state.speed_pin.oe;
  assign autoneg_select_pin_out = state.autoneg_pin.out;
  assign autoneg_select_pin_oe = state.autoneg_pin.oe;
  assign duplex_select_pin_out = state.duplex_pin.out;
  assign duplex_select_pin_oe = state.duplex_pin.oe;
  assign descrambler_lock_out = state.lock;
  assign link_status_out = state.link;
  assign signal_detect_out = state.sd;
  assign carrier_sense = state.crs;
  assign sqe_test_enable = state.sqe_en;
  assign host_if_mode = state.if_mode;
  assign sw_mode_out = state.sw_mode;
  assign speed_100 = state.eff.speed_100;
  assign full_duplex = state.eff.full_duplex;
  assign autoneg_enable = state.eff.autoneg;
  assign repeater_mode = state.repeater;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  // Every check but reset_state_a and read_once_a that looks back one cycle is armed only from an edge with reset
  // released: the edge that loads the reset state must not be held against the
  // inputs that it ignored.

  // Mode follows the source select
  mode_select_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rst_n |=> sw_mode_out == $past(config_source_select))
    else $error("mode does not follow config source");

  // Hardware mode takes speed and duplex from the pins
  hw_speed_duplex_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rst_n && !config_source_select |=> (speed_100 == $past(speed_select_pin_in))
      && (full_duplex == $past(duplex_select_pin_in)) && !speed_select_pin_oe)
    else $error("hardware mode speed or duplex wrong");

  // Hardware mode takes auto-negotiation from the pin
  hw_autoneg_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rst_n && !config_source_select |=> autoneg_enable == $past(autoneg_select_pin_in)
      && !autoneg_select_pin_oe && !duplex_select_pin_oe)
    else $error("hardware mode autoneg wrong");

  // Hardware mode leaves the released pins low on the device side
  hw_pins_quiet_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rst_n && !config_source_select |=> !speed_select_pin_out && !autoneg_select_pin_out
      && !duplex_select_pin_out)
    else $error("hardware mode pin still driven high");

  // Software mode drives all three pins with the reported settings
  sw_pin_drive_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rst_n && config_source_select |=> speed_select_pin_oe && autoneg_select_pin_oe
      && duplex_select_pin_oe && speed_select_pin_out == speed_100
      && autoneg_select_pin_out == autoneg_enable && duplex_select_pin_out == full_duplex)
    else $error("software mode pin drive wrong");

  // Software mode settings trail the control register by one cycle
  sw_eff_follow_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rst_n && config_source_select |=> speed_100 == $past(state.ctrl.speed_100)
      && full_duplex == $past(state.ctrl.full_duplex)
      && autoneg_enable == $past(state.ctrl.autoneg))
    else $error("software settings do not follow control");

  // Software mode settings come from a control write
  sw_ctrl_source_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (rst_n && reg_req.wr && reg_req.addr == CTRL_ADDR)
      ##1 (config_source_select && !reg_req.wr) ##1 config_source_select
      |=> speed_100 == $past(reg_req.wdata[CTRL_SPEED_BIT], 3)
      && full_duplex == $past(reg_req.wdata[CTRL_DUPLEX_BIT], 3)
      && autoneg_enable == $past(reg_req.wdata[CTRL_AUTONEG_BIT], 3))
    else $error("software settings not from control register");

  // Control writes land in the control register
  ctrl_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rst_n && reg_req.wr && reg_req.addr == CTRL_ADDR
      |=> state.ctrl.speed_100 == $past(reg_req.wdata[CTRL_SPEED_BIT])
      && state.ctrl.full_duplex == $past(reg_req.wdata[CTRL_DUPLEX_BIT])
      && state.ctrl.autoneg == $past(reg_req.wdata[CTRL_AUTONEG_BIT]))
    else $error("control write lost");

  // Nothing but a control write changes the control register
  ctrl_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rst_n && !(reg_req.wr && reg_req.addr == CTRL_ADDR) |=> $stable(state.ctrl))
    else $error("control register changed without a write");

  // Interface mode decode
  if_mode_map_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rst_n |=> host_if_mode == decode_if(speed_100, $past(host_if_select),
                                        $past(serial_or_pulse_select)))
    else $error("host interface mode wrong");

  // MII exactly when the host select is low, one mode at a time
  if_mii_select_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rst_n |=> (host_if_mode == IF_MII) == !$past(host_if_select) && $onehot(host_if_mode))
    else $error("host interface select not honoured");

  // Serial or pulse select ignored outside 10M stream
  sp_ignored_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rst_n |=> ($past(host_if_select) && !speed_100)
      || host_if_mode inside {IF_MII, IF_SYMBOL})
    else $error("serial or pulse select took effect");

  // Lock and link follow their sources
  lock_link_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rst_n |=> descrambler_lock_out == $past(descrambler_locked)
      && link_status_out == $past(link_up))
    else $error("lock or link status wrong");

  // Signal detect only on symbol and serial interfaces
  signal_detect_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rst_n |=> signal_detect_out == ($past(link_up)
      && host_if_mode inside {IF_SYMBOL, IF_SERIAL}))
    else $error("signal detect wrong");

  // No signal detect on the MII or link pulse interfaces
  sd_quiet_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    host_if_mode inside {IF_MII, IF_PULSE} |-> !signal_detect_out)
    else $error("signal detect on wrong interface");

  // Node or repeater steers SQE test
  node_repeater_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rst_n |=> repeater_mode == $past(node_repeater_select)
      && sqe_test_enable == !repeater_mode)
    else $error("node or repeater choice wrong");

  // Carrier sense from transmit only in half-duplex node use
  carrier_sense_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rst_n |=> carrier_sense == ($past(rx_active)
      || ($past(tx_active) && !repeater_mode && !full_duplex)))
    else $error("carrier sense wrong");

  // Receive activity always raises carrier sense
  crs_rx_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rst_n && rx_active |=> carrier_sense)
    else $error("carrier sense missed receive");

  // A repeater ignores its own transmit for carrier sense
  repeater_no_tx_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rst_n && node_repeater_select && !rx_active |=> !carrier_sense)
    else $error("repeater carrier sense from transmit");

  // Read data stands one cycle only
  read_once_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !reg_req.rd |=> reg_rdata == 32'h0)
    else $error("read data outside read cycle");

  // Control reads return the settings held before the read edge
  ctrl_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rst_n && reg_req.rd && reg_req.addr == CTRL_ADDR
      |=> reg_rdata[CTRL_SPEED_BIT] == $past(state.ctrl.speed_100)
      && reg_rdata[CTRL_DUPLEX_BIT] == $past(state.ctrl.full_duplex)
      && reg_rdata[CTRL_AUTONEG_BIT] == $past(state.ctrl.autoneg))
    else $error("control read wrong");

  // Status reads return the status word
  stat_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rst_n && reg_req.rd && reg_req.addr == STAT_ADDR |=> reg_rdata == $past(status_word))
    else $error("status read wrong");

  // Unmapped reads return zero
  unmapped_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rst_n && reg_req.rd && reg_req.addr != CTRL_ADDR && reg_req.addr != STAT_ADDR
      |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");

  // Reset drops the pin drives and parks the interface on the MII
  reset_state_a: assert property (@(posedge ref_clk)
    !rst_n |=> !speed_select_pin_oe && !autoneg_select_pin_oe && !duplex_select_pin_oe
      && host_if_mode == IF_MII && reg_rdata == 32'h0)
    else $error("reset state wrong");

  // Main scenarios
  symbol_sd_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    signal_detect_out && host_if_mode == IF_SYMBOL);
  sw_mode_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    config_source_select ##2 speed_select_pin_oe);
  pulse_if_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    host_if_mode == IF_PULSE);
  serial_sd_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    signal_detect_out && host_if_mode == IF_SERIAL);
  tx_crs_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    carrier_sense && !$past(rx_active));

endmodule // phy_config_strap_decode

// >>> hw/phy_strap_pkg.sv
// Purpose: Constants and types for the strap decode block of the PHY.
// Assumes: One 25 MHz clock, synchronous active-low reset.
// Notes: Register offsets are byte addresses on the plain register port.
package phy_strap_pkg;

  // Register map
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STAT_ADDR = 8'h04;

  // Control register fields
  localparam int CTRL_SPEED_BIT = 0;
  localparam int CTRL_DUPLEX_BIT = 1;
  localparam int CTRL_AUTONEG_BIT = 2;

  // Status register fields
  localparam int STAT_SW_BIT = 0;
  localparam int STAT_SPEED_BIT = 1;
  localparam int STAT_DUPLEX_BIT = 2;
  localparam int STAT_AUTONEG_BIT = 3;
  localparam int STAT_REPEATER_BIT = 4;
  localparam int STAT_IF_LSB = 5;
  localparam int STAT_LOCK_BIT = 9;
  localparam int STAT_LINK_BIT = 10;

  // Host interface modes
  typedef enum logic [3:0] {
    IF_MII = 4'h1,
    IF_SYMBOL = 4'h2,
    IF_SERIAL = 4'h4,
    IF_PULSE = 4'h8
  } if_mode_type;

  // Link settings
  typedef struct packed {
    logic speed_100;
    logic full_duplex;
    logic autoneg;
  } link_cfg_type;

  localparam link_cfg_type CTRL_RESET = '{speed_100: 1'b1, full_duplex: 1'b0, autoneg: 1'b1};

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;

  // Drive of a two-way pin
  typedef struct packed {
    logic out;
    logic oe;
  } pin_drive_type;

  // Whole block state
  typedef struct packed {
    link_cfg_type ctrl;
    link_cfg_type eff;
    logic sw_mode;
    logic repeater;
    if_mode_type if_mode;
    pin_drive_type speed_pin;
    pin_drive_type duplex_pin;
    pin_drive_type autoneg_pin;
    logic lock;
    logic link;
    logic sd;
    logic crs;
    logic sqe_en;
    logic [31:0] rdata;
  } strap_state_type;

endpackage

// >>> testbench/strap_board_model.sv
// Purpose: Board side of the three two-way strap pins.
// Assumes: Each pin has a strap resistor; the device overrides it while driving.
// Notes: Pure wiring, no clock.
`timescale 1ns/1ps

module strap_board_model (
  input wire logic speed_strap,
  input wire logic duplex_strap,
  input wire logic autoneg_strap,
  input wire logic speed_out,
  input wire logic speed_oe,
  input wire logic duplex_out,
  input wire logic duplex_oe,
  input wire logic autoneg_out,
  input wire logic autoneg_oe,
  output logic speed_level,
  output logic duplex_level,
  output logic autoneg_level
);
  // Resistor level unless the device drives the pin
  assign speed_level = speed_oe ? speed_out : speed_strap;
  assign duplex_level = duplex_oe ? duplex_out : duplex_strap;
  assign autoneg_level = autoneg_oe ? autoneg_out : autoneg_strap;
endmodule // strap_board_model

// >>> testbench/phy_config_strap_decode_tb.sv
// Purpose: Random strap and register traffic checked against a bench model.
// Assumes: Inputs held three edges before outputs are compared.
// Notes: Model control register kept in bit order speed, duplex, autoneg.
`timescale 1ns/1ps

module phy_config_strap_decode_tb;
  import phy_strap_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n;
  reg_req_type reg_req;
  logic [31:0] reg_rdata;
  logic cfg_src, sp_strap, dp_strap, an_strap, host_sel, sop_sel, nr_sel, locked, lnk, rx, tx;
  logic sp_lvl, dp_lvl, an_lvl, sp_out, sp_oe, dp_out, dp_oe, an_out, an_oe;
  logic lock_o, link_status_out_o, sd_o, crs_o, sqe_o, sw_o, spd_o, dup_o, an_o, rep_o;
  if_mode_type ifm_o;
  logic [2:0] m_ctrl;
  logic [15:0] rnd;
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;

  phy_config_strap_decode u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .config_source_select(cfg_src), .speed_select_pin_in(sp_lvl),
    .speed_select_pin_out(sp_out), .speed_select_pin_oe(sp_oe), .autoneg_select_pin_in(an_lvl),
    .autoneg_select_pin_out(an_out), .autoneg_select_pin_oe(an_oe),
    .duplex_select_pin_in(dp_lvl), .duplex_select_pin_out(dp_out), .duplex_select_pin_oe(dp_oe),
    .host_if_select(host_sel), .serial_or_pulse_select(sop_sel), .node_repeater_select(nr_sel),
    .descrambler_locked(locked), .link_up(lnk), .rx_active(rx), .tx_active(tx),
    .descrambler_lock_out(lock_o), .link_status_out(link_status_out_o), .signal_detect_out(sd_o),
    .carrier_sense(crs_o), .sqe_test_enable(sqe_o), .host_if_mode(ifm_o), .sw_mode_out(sw_o),
    .speed_100(spd_o), .full_duplex(dup_o), .autoneg_enable(an_o), .repeater_mode(rep_o));

  strap_board_model u_board (.speed_strap(sp_strap), .duplex_strap(dp_strap),
    .autoneg_strap(an_strap), .speed_out(sp_out), .speed_oe(sp_oe), .duplex_out(dp_out),
    .duplex_oe(dp_oe), .autoneg_out(an_out), .autoneg_oe(an_oe), .speed_level(sp_lvl),
    .duplex_level(dp_lvl), .autoneg_level(an_lvl));

  ////////////////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  always #20 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 10000) begin
      mismatches++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return s[0] ? ((s >> 1) ^ 16'hb400) : (s >> 1);
  endfunction

  // Expected status word from the present inputs and model control
  function automatic logic [31:0] exp_stat();
    logic spd, dup, an;
    logic [3:0] ifm;
    spd = cfg_src ? m_ctrl[0] : sp_strap;
    dup = cfg_src ? m_ctrl[1] : dp_strap;
    an = cfg_src ? m_ctrl[2] : an_strap;
    if (!host_sel) ifm = 4'h1;
    else if (spd) ifm = 4'h2;
    else ifm = sop_sel ? 4'h8 : 4'h4;
    return {21'h0, lnk, locked, ifm, nr_sel, an, dup, spd, cfg_src};
  endfunction

  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", name, e, g);
    end
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_req.addr <= a;
    reg_req.rd <= 1'b1;
    @(posedge ref_clk);
    reg_req.rd <= 1'b0;
    @(negedge ref_clk);
    chk("reg_rdata", e, reg_rdata);
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_req.addr <= a;
    reg_req.wdata <= d;
    reg_req.wr <= 1'b1;
    @(posedge ref_clk);
    reg_req.wr <= 1'b0;
    if (a == CTRL_ADDR) m_ctrl = d[2:0];
  endtask

  // Every output against the model
  task automatic check_all();
    logic [31:0] s;
    s = exp_stat();
    chk("sw_mode_out", s[0], sw_o);
    chk("speed_100", s[1], spd_o);
    chk("full_duplex", s[2], dup_o);
    chk("autoneg_enable", s[3], an_o);
    chk("speed_pin", {cfg_src, cfg_src & m_ctrl[0]}, {sp_oe, sp_out});
    chk("duplex_pin", {cfg_src, cfg_src & m_ctrl[1]}, {dp_oe, dp_out});
    chk("autoneg_pin", {cfg_src, cfg_src & m_ctrl[2]}, {an_oe, an_out});
    chk("host_if_mode", s[8:5], ifm_o);
    chk("lock", locked, lock_o);
    chk("link_status", lnk, link_status_out_o);
    chk("signal_detect", lnk & (s[6] | s[7]), sd_o);
    chk("mode", {nr_sel, !nr_sel}, {rep_o, sqe_o});
    chk("carrier_sense", (!s[2] && !nr_sel) ? (rx | tx) : rx, crs_o);
    chk("reg_rdata_idle", 32'h0, reg_rdata);
  endtask

  task automatic stop_test();
    if (mismatches == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_n = 1'b0;
    reg_req = '0;
    {cfg_src, sp_strap, dp_strap, an_strap, host_sel, sop_sel, nr_sel, locked, lnk, rx, tx} = '0;
    m_ctrl = {CTRL_RESET.autoneg, CTRL_RESET.full_duplex, CTRL_RESET.speed_100};
    rnd = 16'he6d2;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    chk_rd(CTRL_ADDR, {29'h0, m_ctrl});
    for (int i = 0; i < 200; i++) begin
      rnd = lfsr(rnd);
      @(posedge ref_clk);
      {cfg_src, sp_strap, dp_strap, an_strap, host_sel, sop_sel, nr_sel, locked, lnk, rx, tx}
        <= rnd[10:0];
      if (rnd[11]) reg_wr(rnd[13] ? CTRL_ADDR : (rnd[12] ? STAT_ADDR : 8'h08), {lfsr(rnd), rnd});
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      check_all();
      chk_rd(STAT_ADDR, exp_stat());
      chk_rd(CTRL_ADDR, {29'h0, m_ctrl});
      chk_rd(rnd[7:0] | 8'h08, 32'h0);
      if (i == 100) begin
        // Second reset in mid-run drops pin drives and restores control
        @(posedge ref_clk);
        rst_n <= 1'b0;
        @(posedge ref_clk);
        @(negedge ref_clk);
        chk("reset_oe", 3'b000, {sp_oe, dp_oe, an_oe});
        @(posedge ref_clk);
        rst_n <= 1'b1;
        m_ctrl = {CTRL_RESET.autoneg, CTRL_RESET.full_duplex, CTRL_RESET.speed_100};
      end
    end
    stop_test();
  end
endmodule // phy_config_strap_decode_tb
